// *** design/kbch_host_channel.sv ***
// Keyboard/PM host channel: core registers, host ports, host IRQ drivers
`timescale 1ns/1ns

module kbch_fifo #(
    parameter int WIDTH = 9,
    parameter int DEPTH = 8
) (
    // Clock and reset
    input  wire logic             clk_in,
    input  wire logic             rst_n_in,
    // Fill side
    input  wire logic             in_valid_in,
    output logic                  in_ready_out,
    input  wire logic [WIDTH-1:0] in_data_in,
    // Drain side
    output logic                  out_valid_out,
    input  wire logic             out_ready_in,
    output logic      [WIDTH-1:0] out_data_out
);
    localparam int PW = $clog2(DEPTH);
    localparam logic [PW:0] FULL_COUNT = (PW+1)'(DEPTH);

    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [PW-1:0]    wr_ptr_q;
    logic [PW-1:0]    rd_ptr_q;
    logic [PW:0]      count_q;
    wire              push = in_valid_in && in_ready_out;
    wire              pop  = out_valid_out && out_ready_in;

    assign in_ready_out  = (count_q != FULL_COUNT);
    assign out_valid_out = (count_q != '0);
    assign out_data_out  = mem_q[rd_ptr_q];

    always_ff @(posedge clk_in) begin
        if (push) begin
            mem_q[wr_ptr_q] <= in_data_in;
        end
    end

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            wr_ptr_q <= '0;
            rd_ptr_q <= '0;
            count_q  <= '0;
        end else begin
            if (push) begin
                wr_ptr_q <= PW'(wr_ptr_q + 1'b1);
            end
            if (pop) begin
                rd_ptr_q <= PW'(rd_ptr_q + 1'b1);
            end
            count_q <= (PW+1)'(count_q + push - pop);
        end
    end
endmodule // kbch_fifo

module kbch_host_channel
    import kbch_pkg::*;
(
    // Clock and reset
    input  wire logic                     clk_in,
    input  wire logic                     rst_n_in,
    // Core register port
    input  wire kbch_pkg::kbch_core_req_s core_req_in,
    output logic                 [7:0]    core_rdata_out,
    // Core interrupt lines
    output logic                          kbd_obe_int_out,
    output logic                          kbd_ibf_int_out,
    output logic                          pm_obe_int_out,
    output logic                          pm_ibf_int_out,
    // Host I/O bus pins
    input  wire kbch_pkg::kbch_host_s     host_bus_in,
    output logic                 [7:0]    host_data_out,
    output logic                          host_data_oe_out,
    output logic                          host_ready_out,
    // Host IRQ pins, index 0 IRQ1, 1 IRQ12, 2 IRQ11
    input  wire logic            [2:0]    irq_pin_in,
    output logic                 [2:0]    irq_pin_out,
    output logic                 [2:0]    irq_pin_oe_out
);
    import kbch_pkg::*;

    // Reserved codes give the shortest pulse
    function automatic logic [4:0] pulse_len(input logic [2:0] mode);
        case (mode)
            3'h1:    pulse_len = PULSE_1;
            3'h2:    pulse_len = PULSE_2;
            3'h3:    pulse_len = PULSE_4;
            3'h4:    pulse_len = PULSE_8;
            3'h5:    pulse_len = PULSE_16;
            3'h0:    pulse_len = PULSE_NONE;
            default: pulse_len = PULSE_1;
        endcase
    endfunction

    // Registers
    logic [7:0]    ctrl_q;
    logic [7:0]    irqc_q;
    logic [7:0]    kstat_q;
    logic [7:0]    pstat_q;
    logic [7:0]    kout_q;
    logic [7:0]    kin_q;
    logic [7:0]    pout_q;
    logic [7:0]    pin_q;
    logic          src_mouse_q;
    logic [7:0]    rdata_q;
    logic [7:0]    host_dout_q;
    logic [2:0]    irq_q;
    logic [4:0]    pulse_cnt_q [3];
    logic [2:0]    irq_s1_q;
    logic [2:0]    irq_s2_q;
    kbch_host_s    host_s1_q;
    kbch_host_s    host_s2_q;
    kbch_host_s    host_s3_q;

    // Core address decode
    wire core_wr     = core_req_in.wr;
    wire core_rd     = core_req_in.rd;

    wire wr_ctrl     = core_wr && (core_req_in.addr == CTRL_ADDR);
    wire wr_irqc     = core_wr && (core_req_in.addr == IRQC_ADDR);
    wire wr_kstat    = core_wr && (core_req_in.addr == KSTAT_ADDR);
    wire wr_kdo      = core_wr && (core_req_in.addr == KDO_ADDR);
    wire wr_mdo      = core_wr && (core_req_in.addr == MDO_ADDR);
    wire wr_pstat    = core_wr && (core_req_in.addr == PSTAT_ADDR);
    wire wr_pdo      = core_wr && (core_req_in.addr == PDO_ADDR);
    wire rd_kdi      = core_rd && (core_req_in.addr == KDI_ADDR);
    wire rd_pdi      = core_rd && (core_req_in.addr == PDI_ADDR);

    // Host strobes, seen after the two-stage synchroniser
    wire host_rd_rise = host_s2_q.rd && !host_s3_q.rd;
    wire host_wr_rise = host_s2_q.wr && !host_s3_q.wr;

    wire [9:0] haddr  = host_s2_q.addr;
    wire sel_kdata    = (haddr == HOST_KDATA);
    wire sel_kcmd     = (haddr == HOST_KCMD);
    wire sel_pdata    = (haddr == HOST_PDATA);
    wire sel_pcmd     = (haddr == HOST_PCMD);
    wire sel_any      = sel_kdata || sel_kcmd || sel_pdata || sel_pcmd;

    wire host_rd_kd   = host_rd_rise && sel_kdata;
    wire host_rd_pd   = host_rd_rise && sel_pdata;
    wire host_wr_kbc  = host_wr_rise && (sel_kdata || sel_kcmd);
    wire host_wr_pm   = host_wr_rise && (sel_pdata || sel_pcmd);
    wire host_a2      = haddr[HOST_A2_BIT];

    // Host writes to the keyboard channel queue here; IRQ-free hosts may burst
    kbch_in_word_s fifo_in_word;
    kbch_in_word_s fifo_out_word;
    logic          fifo_in_ready;
    logic          fifo_out_valid;
    wire           fifo_out_ready = !kstat_q[STAT_IBF];
    wire           fifo_pop       = fifo_out_valid && fifo_out_ready;

    assign fifo_in_word.a2   = host_a2;
    assign fifo_in_word.data = host_s2_q.data;

    kbch_fifo #(
        .WIDTH (IN_FIFO_WIDTH),
        .DEPTH (IN_FIFO_DEPTH)
    ) u_in_fifo (
        .clk_in        (clk_in),
        .rst_n_in      (rst_n_in),
        .in_valid_in   (host_wr_kbc),
        .in_ready_out  (fifo_in_ready),
        .in_data_in    (fifo_in_word),
        .out_valid_out (fifo_out_valid),
        .out_ready_in  (fifo_out_ready),
        .out_data_out  (fifo_out_word)
    );

    // Host IRQ line generation
    wire [2:0] hw_en  = {ctrl_q[CTRL_PM_IE], ctrl_q[CTRL_MOUSE_IE], ctrl_q[CTRL_KBD_IE]};
    wire [2:0] trig   = {wr_pdo, wr_mdo, wr_kdo};
    wire [2:0] lvl_req = {pstat_q[STAT_OBF],
                          kstat_q[STAT_OBF] && src_mouse_q,
                          kstat_q[STAT_OBF] && !src_mouse_q};

    wire [2:0] irq_mode   = irqc_q[IRQC_MODE_LO +: 3];
    wire       pulse_mode = (irq_mode != MODE_LEVEL);
    wire       npol       = irqc_q[IRQC_NPOL];
    wire       push_pull  = irqc_q[IRQC_PUSH_PULL];

    logic [2:0] hw_val;
    logic [2:0] irq_d;

    always_comb begin
        irq_d  = '0;
        hw_val = '0;
        for (int i = 0; i < 3; i++) begin
            hw_val[i] = pulse_mode ? (pulse_cnt_q[i] == PULSE_NONE) : lvl_req[i];
            irq_d[i]  = hw_en[i] ? (hw_val[i] ^ npol) : irqc_q[i];
        end
    end

    // Open drain floats on one; push-pull drives both levels
    assign irq_pin_out    = push_pull ? irq_q : 3'h0;
    assign irq_pin_oe_out = push_pull ? 3'h7 : ~irq_q;

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            irq_q <= '0;
            for (int i = 0; i < 3; i++) pulse_cnt_q[i] <= PULSE_NONE;
        end else begin
            irq_q <= irq_d;
            for (int i = 0; i < 3; i++) begin
                if (trig[i] && pulse_mode) begin
                    pulse_cnt_q[i] <= pulse_len(irq_mode);
                end else if (pulse_cnt_q[i] != PULSE_NONE) begin
                    pulse_cnt_q[i] <= 5'(pulse_cnt_q[i] - 1'b1);
                end
            end
        end
    end

    // Pin sampling for host inputs and IRQ readback
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            host_s1_q <= '0;
            host_s2_q <= '0;
            host_s3_q <= '0;
            irq_s1_q  <= '0;
            irq_s2_q  <= '0;
        end else begin
            host_s1_q <= host_bus_in;
            host_s2_q <= host_s1_q;
            host_s3_q <= host_s2_q;
            irq_s1_q  <= irq_pin_in;
            irq_s2_q  <= irq_s1_q;
        end
    end

    // Control and IRQ control registers
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            ctrl_q <= CTRL_RST;
            irqc_q <= IRQC_RST;
        end else begin
            if (wr_ctrl) ctrl_q <= core_req_in.wdata & CTRL_MASK;
            if (wr_irqc) irqc_q <= core_req_in.wdata;
        end
    end

    // Keyboard channel status and buffers; set wins over clear
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            kstat_q     <= STAT_RST;
            kout_q      <= BYTE_ZERO;
            kin_q       <= BYTE_ZERO;
            src_mouse_q <= 1'b0;
        end else begin
            if (wr_kstat) begin
                kstat_q <= (kstat_q & ~STAT_FW_MASK) | (core_req_in.wdata & STAT_FW_MASK);
            end
            if (wr_kdo || wr_mdo) begin
                kout_q              <= core_req_in.wdata;
                src_mouse_q         <= wr_mdo;
                kstat_q[STAT_OBF]   <= 1'b1;
            end else if (host_rd_kd) begin
                kstat_q[STAT_OBF]   <= 1'b0;
            end
            if (fifo_pop) begin
                kin_q               <= fifo_out_word.data;
                kstat_q[STAT_A2]    <= fifo_out_word.a2;
                kstat_q[STAT_IBF]   <= 1'b1;
            end else if (rd_kdi) begin
                kstat_q[STAT_IBF]   <= 1'b0;
            end
        end
    end

    // PM channel status and buffers
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            pstat_q <= STAT_RST;
            pout_q  <= BYTE_ZERO;
            pin_q   <= BYTE_ZERO;
        end else begin
            if (wr_pstat) begin
                pstat_q <= (pstat_q & ~STAT_FW_MASK) | (core_req_in.wdata & STAT_FW_MASK);
            end
            if (wr_pdo) begin
                pout_q            <= core_req_in.wdata;
                pstat_q[STAT_OBF] <= 1'b1;
            end else if (host_rd_pd) begin
                pstat_q[STAT_OBF] <= 1'b0;
            end
            if (host_wr_pm) begin
                pin_q             <= host_s2_q.data;
                pstat_q[STAT_A2]  <= host_a2;
                pstat_q[STAT_IBF] <= 1'b1;
            end else if (rd_pdi) begin
                pstat_q[STAT_IBF] <= 1'b0;
            end
        end
    end

    // Core read data, one cycle after the read strobe
    wire [7:0] irqc_view = (irqc_q & ~IRQC_DIRECT_MASK) | {5'h00, irq_s2_q};
    logic [7:0] rdata_d;
    always_comb begin
        rdata_d = BYTE_ZERO;
        if (core_req_in.addr == CTRL_ADDR) rdata_d = ctrl_q;
        else if (core_req_in.addr == IRQC_ADDR) rdata_d = irqc_view;
        else if (core_req_in.addr == KSTAT_ADDR) rdata_d = kstat_q;
        else if (core_req_in.addr == KDI_ADDR) rdata_d = kin_q;
        else if (core_req_in.addr == PSTAT_ADDR) rdata_d = pstat_q;
        else if (core_req_in.addr == PDI_ADDR) rdata_d = pin_q;
    end

    // Host read data is latched at the strobe edge and held while it stays high
    logic [7:0] host_dout_d;
    always_comb begin
        host_dout_d = BYTE_ZERO;
        if (sel_kdata) host_dout_d = kout_q;
        else if (sel_kcmd) host_dout_d = kstat_q;
        else if (sel_pdata) host_dout_d = pout_q;
        else if (sel_pcmd) host_dout_d = pstat_q;
    end

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            rdata_q     <= BYTE_ZERO;
            host_dout_q <= BYTE_ZERO;
        end else begin
            if (core_rd) rdata_q <= rdata_d;
            if (host_rd_rise) host_dout_q <= host_dout_d;
        end
    end

    assign core_rdata_out   = rdata_q;
    assign host_data_out    = host_dout_q;
    assign host_data_oe_out = host_s2_q.rd && host_s3_q.rd && sel_any;

    // Host must hold off keyboard-port writes while this is low
    assign host_ready_out   = fifo_in_ready;

    // Core interrupt levels
    assign kbd_obe_int_out = ctrl_q[CTRL_OBE_CIE] && !kstat_q[STAT_OBF];
    assign kbd_ibf_int_out = ctrl_q[CTRL_IBF_CIE] && kstat_q[STAT_IBF];
    assign pm_obe_int_out  = ctrl_q[CTRL_PM_OBE_CIE] && !pstat_q[STAT_OBF];
    assign pm_ibf_int_out  = ctrl_q[CTRL_PM_IBF_CIE] && pstat_q[STAT_IBF];
endmodule // kbch_host_channel

// *** design/kbch_pkg.sv ***
// Constants, register map and carrier types of the keyboard host channel
package kbch_pkg;
    // Core-side register addresses
    localparam logic [15:0] CTRL_ADDR     = 16'hfea0;
    localparam logic [15:0] IRQC_ADDR     = 16'hfea2;
    localparam logic [15:0] KSTAT_ADDR    = 16'hfea4;
    localparam logic [15:0] KDO_ADDR      = 16'hfea6;
    localparam logic [15:0] MDO_ADDR      = 16'hfea8;
    localparam logic [15:0] KDI_ADDR      = 16'hfeaa;
    localparam logic [15:0] PSTAT_ADDR    = 16'hfeac;
    localparam logic [15:0] PDO_ADDR      = 16'hfeae;
    localparam logic [15:0] PDI_ADDR      = 16'hfeb0;
    // Host I/O ports
    localparam logic [9:0]  HOST_KDATA    = 10'h060;
    localparam logic [9:0]  HOST_KCMD     = 10'h064;
    localparam logic [9:0]  HOST_PDATA    = 10'h062;
    localparam logic [9:0]  HOST_PCMD     = 10'h066;
    localparam int          HOST_A2_BIT   = 2;
    // Control register fields
    localparam int CTRL_KBD_IE     = 0;
    localparam int CTRL_MOUSE_IE   = 1;
    localparam int CTRL_OBE_CIE    = 2;
    localparam int CTRL_IBF_CIE    = 3;
    localparam int CTRL_PM_IE      = 4;
    localparam int CTRL_PM_OBE_CIE = 5;
    localparam int CTRL_PM_IBF_CIE = 6;
    localparam logic [7:0] CTRL_MASK  = 8'h7f;
    // IRQ control fields
    localparam int IRQC_MODE_LO    = 3;
    localparam int IRQC_NPOL       = 6;
    localparam int IRQC_PUSH_PULL  = 7;
    localparam logic [7:0] IRQC_DIRECT_MASK = 8'h07;
    // Status fields
    localparam int STAT_OBF        = 0;
    localparam int STAT_IBF        = 1;
    localparam int STAT_A2         = 3;
    localparam logic [7:0] STAT_FW_MASK = 8'hf4;
    // Reset values
    localparam logic [7:0] CTRL_RST   = 8'h00;
    localparam logic [7:0] IRQC_RST   = 8'h07;
    localparam logic [7:0] STAT_RST   = 8'h00;
    localparam logic [7:0] BYTE_ZERO  = 8'h00;
    // Pulse-mode widths in core clocks
    localparam logic [2:0] MODE_LEVEL = 3'h0;
    localparam logic [4:0] PULSE_1    = 5'h01;
    localparam logic [4:0] PULSE_2    = 5'h02;
    localparam logic [4:0] PULSE_4    = 5'h04;
    localparam logic [4:0] PULSE_8    = 5'h08;
    localparam logic [4:0] PULSE_16   = 5'h10;
    localparam logic [4:0] PULSE_NONE = 5'h00;
    // Input FIFO shape
    localparam int IN_FIFO_DEPTH = 8;
    localparam int IN_FIFO_WIDTH = 9;

    typedef struct packed {
        logic [9:0] addr;
        logic [7:0] data;
        logic       rd;
        logic       wr;
    } kbch_host_s;

    typedef struct packed {
        logic [15:0] addr;
        logic [7:0]  wdata;
        logic        wr;
        logic        rd;
    } kbch_core_req_s;

    typedef struct packed {
        logic       a2;
        logic [7:0] data;
    } kbch_in_word_s;
endpackage

// *** tb/kbch_host_channel_monitor.sv ***
// Port-level assertion checker for the keyboard host channel
`timescale 1ns/1ns
module kbch_host_channel_monitor
    import kbch_pkg::*;
(
    // Clock and reset
    input wire logic                     clk_in,
    input wire logic                     rst_n_in,
    // Core side
    input wire kbch_pkg::kbch_core_req_s core_req_in,
    input wire logic [7:0]               core_rdata_out,
    input wire logic                     kbd_obe_int_out,
    input wire logic                     kbd_ibf_int_out,
    input wire logic                     pm_obe_int_out,
    input wire logic                     pm_ibf_int_out,
    // Host side
    input wire kbch_pkg::kbch_host_s     host_bus_in,
    input wire logic [7:0]               host_data_out,
    input wire logic                     host_data_oe_out,
    input wire logic                     host_ready_out,
    input wire logic [2:0]               irq_pin_in,
    input wire logic [2:0]               irq_pin_out,
    input wire logic [2:0]               irq_pin_oe_out
);
    logic [7:0] ctrl_q;
    logic [7:0] irqc_q;
    wire        wr_w  = core_req_in.wr;
    wire        kdo_w = wr_w && core_req_in.addr == KDO_ADDR;
    wire        od_w  = !irqc_q[7];
    wire        kirq_w = kdo_w && ctrl_q[0] && od_w;

    // Shadows of the control registers, updated on the same edge as the design's
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            ctrl_q <= CTRL_RST;
            irqc_q <= IRQC_RST;
        end else if (wr_w && core_req_in.addr == CTRL_ADDR) begin
            ctrl_q <= core_req_in.wdata & CTRL_MASK;
        end else if (wr_w && core_req_in.addr == IRQC_ADDR) begin
            irqc_q <= core_req_in.wdata;
        end
    end

    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!rst_n_in);

    a_kdo_obe_drop: assert property (kdo_w |=> !kbd_obe_int_out)
        else $error("empty interrupt after kbd write");
    a_mdo_obe_drop: assert property (wr_w && core_req_in.addr == MDO_ADDR |=>
        !kbd_obe_int_out) else $error("empty interrupt after mouse write");
    a_pdo_obe_drop: assert property (wr_w && core_req_in.addr == PDO_ADDR |=>
        !pm_obe_int_out) else $error("pm empty interrupt after write");
    a_kdi_ibf_drop: assert property (core_req_in.rd && core_req_in.addr == KDI_ADDR
        && kbd_ibf_int_out |=> !kbd_ibf_int_out) else $error("full interrupt kept");
    a_int_gate_off: assert property ((!kbd_obe_int_out || ctrl_q[2])
        && (!kbd_ibf_int_out || ctrl_q[3]) && (!pm_obe_int_out || ctrl_q[5])
        && (!pm_ibf_int_out || ctrl_q[6])) else $error("core interrupt not enabled");
    a_reset_float: assert property ($rose(rst_n_in) |=> irq_pin_oe_out == 3'b000)
        else $error("irq lines driven after reset");
    a_open_drain: assert property (od_w && $past(od_w) |-> irq_pin_out == 3'b000)
        else $error("open drain drives high");
    a_push_pull: assert property (!od_w && !$past(od_w) |-> irq_pin_oe_out == 3'b111)
        else $error("push-pull not driving");
    a_kbd_level: assert property (kirq_w && irqc_q[6:3] == 4'h0 |->
        ##2 !irq_pin_oe_out[0]) else $error("level irq not raised");
    a_kbd_pulse: assert property (kirq_w && irqc_q[6:3] == 4'h2 |->
        ##2 irq_pin_oe_out[0] [*2] ##1 !irq_pin_oe_out[0]) else $error("pulse width");
    a_npol_invert: assert property (kirq_w && irqc_q[6:3] == 4'h8 |->
        ##2 irq_pin_oe_out[0]) else $error("inverted irq not low");
    a_direct_bit: assert property (wr_w && core_req_in.addr == IRQC_ADDR && !ctrl_q[0]
        && od_w && !core_req_in.wdata[7] |-> ##2
        irq_pin_oe_out[0] != $past(core_req_in.wdata[0], 2)) else $error("direct bit");
    a_oe_release: assert property (!host_bus_in.rd [*4] |-> !host_data_oe_out)
        else $error("host data driven without read");

    c_pulse: cover property (kirq_w && irqc_q[6:3] == 4'h2);
    c_host_rd: cover property (host_data_oe_out && host_bus_in.addr == HOST_KDATA);
    c_fifo_full: cover property (!host_ready_out);
endmodule // kbch_host_channel_monitor

bind kbch_host_channel kbch_host_channel_monitor kbch_host_channel_monitor_inst (
    .clk_in(clk_in), .rst_n_in(rst_n_in), .core_req_in(core_req_in),
    .core_rdata_out(core_rdata_out), .kbd_obe_int_out(kbd_obe_int_out),
    .kbd_ibf_int_out(kbd_ibf_int_out), .pm_obe_int_out(pm_obe_int_out),
    .pm_ibf_int_out(pm_ibf_int_out), .host_bus_in(host_bus_in),
    .host_data_out(host_data_out), .host_data_oe_out(host_data_oe_out),
    .host_ready_out(host_ready_out), .irq_pin_in(irq_pin_in),
    .irq_pin_out(irq_pin_out), .irq_pin_oe_out(irq_pin_oe_out));

// *** tb/kbch_host_channel_tb.sv ***
// Self-checking bench for the keyboard host channel
`timescale 1ns/1ns
module kbch_host_channel_tb;
    import kbch_pkg::*;
    logic           clk_in   = 1'b0;
    logic           rst_n_in = 1'b0;
    kbch_core_req_s req      = '0;
    kbch_host_s     hbus;
    logic [7:0]     rdata, hdout, b, c, d;
    logic           obe_int, ibf_int, pm_obe, pm_ibf, hoe, hrdy;
    logic [2:0]     irq_out, irq_oe, irq_lvl;
    logic [7:0]     exp_q[$];
    logic           rd_p = 1'b0;
    int             n_fail = 0;
    int             n_compared = 0;
    int             seed = 32'hc6a134d0;
    int             k;

    always #2 clk_in = ~clk_in;

    kbch_host_channel kbch_host_channel_inst (.clk_in(clk_in), .rst_n_in(rst_n_in),
        .core_req_in(req), .core_rdata_out(rdata), .kbd_obe_int_out(obe_int),
        .kbd_ibf_int_out(ibf_int), .pm_obe_int_out(pm_obe), .pm_ibf_int_out(pm_ibf),
        .host_bus_in(hbus), .host_data_out(hdout), .host_data_oe_out(hoe),
        .host_ready_out(hrdy), .irq_pin_in(irq_lvl), .irq_pin_out(irq_out),
        .irq_pin_oe_out(irq_oe));
    kbch_host_model kbch_host_model_inst (.clk_in(clk_in), .host_bus_out(hbus),
        .host_data_in(hdout), .host_data_oe_in(hoe), .irq_pin_in(irq_out),
        .irq_oe_in(irq_oe), .irq_level_out(irq_lvl));

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_compared++;
        if (got !== exp) begin
            n_fail++;
            $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // Read data is registered, so it is judged half a cycle after the taking edge
    always @(negedge clk_in) begin
        if (rd_p) begin
            if (exp_q.size() == 0) begin
                n_fail++;
                $display("MISMATCH at %0t: unexpected read", $time);
            end else begin
                chk(rdata, exp_q.pop_front());
            end
        end
        rd_p = req.rd;
    end

    task automatic wait_n(input int n);
        repeat (n) @(posedge clk_in);
        #1;
    endtask

    task automatic core_wr(input logic [15:0] a, input logic [7:0] v);
        @(posedge clk_in);
        req <= '{addr: a, wdata: v, wr: 1'b1, rd: 1'b0};
        @(posedge clk_in);
        req.wr <= 1'b0;
    endtask

    task automatic core_rd(input logic [15:0] a, input logic [7:0] e);
        exp_q.push_back(e);
        @(posedge clk_in);
        req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge clk_in);
        req.rd <= 1'b0;
        wait_n(2);
    endtask

    task automatic host_rd(input logic [9:0] a, input logic [7:0] e);
        logic [7:0] v;
        logic       ok;
        kbch_host_model_inst.io_read(a, v, ok);
        if (!ok) begin
            n_fail++;
            $display("MISMATCH at %0t: host read unanswered", $time);
            close_out();
        end
        chk(v, e);
    endtask

    task automatic close_out();
        $display("compared %0d, mismatches %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    initial begin
        repeat (5) @(posedge clk_in);
        rst_n_in <= 1'b1;
        wait_n(4);
        core_rd(CTRL_ADDR, CTRL_RST);
        core_rd(IRQC_ADDR, IRQC_RST);
        core_rd(KSTAT_ADDR, STAT_RST);
        core_rd(PSTAT_ADDR, STAT_RST);
        core_rd(16'hfeb2, BYTE_ZERO);
        b = 8'($random(seed));
        core_wr(KSTAT_ADDR, b);
        core_rd(KSTAT_ADDR, b & STAT_FW_MASK);
        host_rd(HOST_KCMD, b & STAT_FW_MASK);
        core_wr(KSTAT_ADDR, 8'h00);
        core_wr(CTRL_ADDR, 8'hff);
        core_rd(CTRL_ADDR, CTRL_MASK);
        chk({4'h0, obe_int, ibf_int, pm_obe, pm_ibf}, 8'h0a);
        $display("test registers finished");
        core_wr(KDO_ADDR, b);
        wait_n(3);
        chk({4'h0, obe_int, irq_lvl}, 8'h01);
        core_rd(KSTAT_ADDR, 8'h01);
        host_rd(HOST_KDATA, b);
        host_rd(HOST_KCMD, 8'h00);
        chk({4'h0, obe_int, irq_lvl}, 8'h08);
        c = 8'($random(seed));
        core_wr(MDO_ADDR, c);
        wait_n(3);
        chk({4'h0, obe_int, irq_lvl}, 8'h02);
        host_rd(HOST_KDATA, c);
        d = 8'($random(seed));
        core_wr(PDO_ADDR, d);
        wait_n(3);
        chk({4'h0, pm_obe, irq_lvl}, 8'h04);
        core_rd(PSTAT_ADDR, 8'h01);
        host_rd(HOST_PDATA, d);
        core_rd(PSTAT_ADDR, 8'h00);
        $display("test output path finished");
        kbch_host_model_inst.io_write(HOST_KCMD, b);
        core_rd(KSTAT_ADDR, 8'h0a);
        chk({7'h0, ibf_int}, 8'h01);
        core_rd(KDI_ADDR, b);
        core_rd(KSTAT_ADDR, 8'h08);
        chk({7'h0, ibf_int}, 8'h00);
        kbch_host_model_inst.io_write(HOST_KDATA, c);
        core_rd(KSTAT_ADDR, 8'h02);
        core_rd(KDI_ADDR, c);
        kbch_host_model_inst.io_write(HOST_PCMD, d);
        core_rd(PSTAT_ADDR, 8'h0a);
        chk({7'h0, pm_ibf}, 8'h01);
        core_rd(PDI_ADDR, d);
        core_rd(PSTAT_ADDR, 8'h08);
        $display("test input path finished");
        for (int m = 1; m < 8; m++) begin
            core_wr(IRQC_ADDR, {2'b00, 3'(m), 3'b111});
            wait_n(3);
            core_wr(KDO_ADDR, b);
            k = 0;
            repeat (24) begin
                wait_n(1);
                k += int'(!irq_lvl[0]);
            end
            chk(8'(k), (m > 5) ? 8'h01 : 8'(1 << (m - 1)));
            host_rd(HOST_KDATA, b);
        end
        core_wr(IRQC_ADDR, 8'h40);
        wait_n(3);
        chk({5'h0, irq_lvl}, 8'h07);
        core_wr(KDO_ADDR, c);
        wait_n(3);
        chk({5'h0, irq_lvl}, 8'h06);
        host_rd(HOST_KDATA, c);
        core_wr(CTRL_ADDR, 8'h00);
        core_wr(IRQC_ADDR, 8'h02);
        wait_n(4);
        core_rd(IRQC_ADDR, 8'h02);
        core_wr(IRQC_ADDR, 8'h85);
        wait_n(4);
        chk({5'h0, irq_oe}, 8'h07);
        core_rd(IRQC_ADDR, 8'h85);
        core_wr(IRQC_ADDR, IRQC_RST);
        $display("test irq modes finished");
        // A slow host fills the input FIFO while firmware holds off reading
        kbch_host_model_inst.hold = 7;
        for (int i = 0; i < 10; i++) begin
            kbch_host_model_inst.io_write(HOST_KDATA, 8'h40 + 8'(i));
        end
        chk({7'h0, hrdy}, 8'h00);
        for (int i = 0; i < 9; i++) begin
            core_rd(KDI_ADDR, 8'h40 + 8'(i));
        end
        core_rd(KSTAT_ADDR, 8'h00);
        chk({7'h0, hrdy}, 8'h01);
        $display("test input fifo finished");
        wait_n(4);
        chk(8'(exp_q.size()), 8'h00);
        close_out();
    end

    initial begin
        repeat (40000) @(posedge clk_in);
        $display("MISMATCH at %0t: run did not finish", $time);
        n_fail++;
        close_out();
    end
endmodule // kbch_host_channel_tb

// *** tb/kbch_host_model.sv ***
// Host processor model: I/O port cycles and pulled-up IRQ lines
`timescale 1ns/1ns
module kbch_host_model
    import kbch_pkg::*;
(
    // Clock
    input  wire logic            clk_in,
    // Host I/O bus
    output kbch_pkg::kbch_host_s host_bus_out,
    input  wire logic [7:0]      host_data_in,
    input  wire logic            host_data_oe_in,
    // IRQ lines with board pull-ups
    input  wire logic [2:0]      irq_pin_in,
    input  wire logic [2:0]      irq_oe_in,
    output logic [2:0]           irq_level_out
);
    int         hold = 4;
    int         n;
    logic       drv  = 1'b0;
    logic [7:0] wdat = 8'h00;

    // A released line floats up to the pull-up level
    assign irq_level_out = (irq_pin_in & irq_oe_in) | ~irq_oe_in;
    initial host_bus_out = '0;
    // Idle data lines wander so no stale byte can be mistaken for a write
    always @(posedge clk_in) begin
        host_bus_out.data <= drv ? wdat : ~host_bus_out.data;
    end

    task automatic io_write(input logic [9:0] a, input logic [7:0] v);
        @(posedge clk_in);
        host_bus_out.addr <= a;
        wdat = v;
        drv  = 1'b1;
        repeat (4) @(posedge clk_in);
        host_bus_out.wr <= 1'b1;
        repeat (hold) @(posedge clk_in);
        host_bus_out.wr <= 1'b0;
        repeat (4) @(posedge clk_in);
        drv = 1'b0;
    endtask

    task automatic io_read(input logic [9:0] a, output logic [7:0] v, output logic ok);
        @(posedge clk_in);
        host_bus_out.addr <= a;
        repeat (4) @(posedge clk_in);
        host_bus_out.rd <= 1'b1;
        ok = 1'b0;
        for (n = 0; n < 12 && !ok; n++) begin
            @(negedge clk_in);
            ok = host_data_oe_in;
        end
        v = host_data_in;
        @(posedge clk_in);
        host_bus_out.rd <= 1'b0;
        repeat (4) @(posedge clk_in);
    endtask
endmodule // kbch_host_model
